// ===== rtl/csd_map.svh
// byte positions, codes and reset values of the chip settings command
`ifndef CSD_MAP_SVH
`define CSD_MAP_SVH
`define CSD_CMD_CODE      8'h21
`define CSD_STATUS_OK     8'h00
`define CSD_REPORT_LEN    7'd64
`define CSD_LAST_IDX      6'd63
`define CSD_IDX_CMD       6'd0
`define CSD_IDX_PIN0      6'd4
`define CSD_IDX_PIN8      6'd12
`define CSD_IDX_OUT_LO    6'd13
`define CSD_IDX_DIR_LO    6'd15
`define CSD_IDX_OTHER     6'd17
`define CSD_BIT_WAKE      4
`define CSD_BIT_IRQ_HI    3
`define CSD_BIT_IRQ_LO    1
`define CSD_BIT_HOLD      0
`define CSD_RST_FUNC      2'h0
`define CSD_RST_OUT       8'h00
`define CSD_RST_DIR       8'hFF
`define CSD_RST_IRQ       3'h0
`endif

// ===== rtl/csd_pkg.sv
// types of the chip settings command decoder
package csd_pkg;
	typedef enum logic [1:0] {
		CSD_FN_GPIO = 2'h0,
		CSD_FN_CS   = 2'h1,
		CSD_FN_DED  = 2'h2
	} csd_func_e;
	typedef enum logic [2:0] {
		CSD_IRQ_NONE = 3'h0,
		CSD_IRQ_FALL = 3'h1,
		CSD_IRQ_RISE = 3'h2,
		CSD_IRQ_LOW  = 3'h3,
		CSD_IRQ_HIGH = 3'h4
	} csd_irq_e;
	typedef enum logic [2:0] {
		CSD_ST_RX   = 3'b001,
		CSD_ST_RESP = 3'b010,
		CSD_ST_SKIP = 3'b100
	} csd_state_e;
endpackage

// ===== rtl/csd_decoder.sv
// decoder of the set current chip settings command report
//
// Behaviour
// RQ1: a report whose byte 0 is 21h is decoded as the set-settings command.
// RQ2: bytes 1 to 3 and 18 to 63 are reserved and never feed a setting.
// RQ3: bytes 4 to 11 give pins 0 to 7 function, byte 12 gives pin 8 function.
// RQ4: byte 13 gives default output levels bit n for pin n; byte 14 ignored.
// RQ5: byte 15 gives default directions; byte 16 is ignored by the device.
// RQ6: byte 17 bit 4 enables remote wake-up; bits 7 to 5 are ignored.
// RQ7: byte 17 bits 3 to 1 pick the interrupt counting mode.
// RQ8: byte 17 bit 0 set keeps the SPI bus between transfers, clear frees it.
// RQ9: a 64-byte reply follows, byte 0 echoes 21h, byte 1 is 00h.
// RQ10: direction 1 is input, settings take effect right after the command.
`include "csd_map.svh"
module csd_decoder
	import csd_pkg::*;
(
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       nrst,
	// command report byte stream, first byte starts a report
	input  wire logic       cmd_valid,
	input  wire logic [7:0] cmd_byte,
	output logic            cmd_ready,
	// reply byte stream
	output logic            rsp_valid,
	output logic [7:0]      rsp_byte,
	output logic            rsp_last,
	input  wire logic       rsp_ready,
	// volatile settings
	output logic [17:0]     pin_func,
	output logic [7:0]      gpio_out_default,
	output logic [7:0]      gpio_dir_default,
	output logic            wake_enable,
	output logic [2:0]      irq_count_mode,
	output logic            spi_hold_bus,
	output logic            settings_update
);
	// ****************************************
	// report sequencing
	// ****************************************
	csd_state_e state_reg;
	logic [5:0] idx_reg;
	logic       is_cmd_reg;
	logic [5:0] rsp_idx_reg;
	logic       take;
	logic       end_rx;

	assign take   = cmd_valid && cmd_ready;
	assign end_rx = take && (idx_reg == `CSD_LAST_IDX);

	// other command codes are swallowed whole and get no reply here
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= CSD_ST_RX;
			idx_reg   <= 6'h00;
		end else begin
			unique case (state_reg)
				CSD_ST_RX: begin
					if (take) begin
						idx_reg <= idx_reg + 6'h01;
					end
					if (end_rx) begin
						state_reg <= is_cmd_reg ? CSD_ST_RESP : CSD_ST_RX; // [RQ9]
					end
				end
				CSD_ST_RESP: begin
					if (rsp_ready && rsp_last) begin
						state_reg <= CSD_ST_RX;
					end
				end
				default: begin
					state_reg <= CSD_ST_RX;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			is_cmd_reg <= 1'b0;
		end else if (take && idx_reg == `CSD_IDX_CMD) begin
			is_cmd_reg <= (cmd_byte == `CSD_CMD_CODE); // [RQ1]
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cmd_ready <= 1'b1;
		end else if (end_rx && is_cmd_reg) begin
			cmd_ready <= 1'b0;
		end else if (state_reg == CSD_ST_RESP && rsp_ready && rsp_last) begin
			cmd_ready <= 1'b1;
		end
	end

	// ****************************************
	// staging of fields, committed at report end
	// ****************************************
	logic [17:0] func_stage;
	logic [7:0]  out_stage;
	logic [7:0]  dir_stage;
	logic [4:0]  other_stage;

	// only named bytes load; reserved bytes fall through untouched [RQ2]
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			func_stage  <= '0;
			out_stage   <= `CSD_RST_OUT;
			dir_stage   <= `CSD_RST_DIR;
			other_stage <= '0;
		end else if (take) begin
			if (idx_reg >= `CSD_IDX_PIN0 && idx_reg <= `CSD_IDX_PIN8) begin
				func_stage[2*(idx_reg-`CSD_IDX_PIN0) +: 2] <= cmd_byte[1:0]; // [RQ3]
			end
			if (idx_reg == `CSD_IDX_OUT_LO) begin
				out_stage <= cmd_byte; // [RQ4]
			end
			if (idx_reg == `CSD_IDX_DIR_LO) begin
				dir_stage <= cmd_byte; // [RQ5]
			end
			if (idx_reg == `CSD_IDX_OTHER) begin
				other_stage <= cmd_byte[`CSD_BIT_WAKE:0]; // [RQ6]
			end
		end
	end

	// ****************************************
	// volatile working copy
	// ****************************************
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pin_func         <= '0;
			gpio_out_default <= `CSD_RST_OUT;
			gpio_dir_default <= `CSD_RST_DIR;
			wake_enable      <= 1'b0;
			irq_count_mode   <= `CSD_RST_IRQ;
			spi_hold_bus     <= 1'b0;
		end else if (end_rx && is_cmd_reg) begin
			pin_func         <= func_stage; // [RQ3] [RQ10]
			gpio_out_default <= out_stage; // [RQ4]
			gpio_dir_default <= dir_stage; // [RQ5] [RQ10]
			wake_enable      <= other_stage[`CSD_BIT_WAKE]; // [RQ6]
			irq_count_mode   <=
				other_stage[`CSD_BIT_IRQ_HI:`CSD_BIT_IRQ_LO]; // [RQ7]
			spi_hold_bus     <= other_stage[`CSD_BIT_HOLD]; // [RQ8]
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			settings_update <= 1'b0;
		end else begin
			settings_update <= end_rx && is_cmd_reg; // [RQ10]
		end
	end

	// ****************************************
	// reply
	// ****************************************
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rsp_valid   <= 1'b0;
			rsp_byte    <= 8'h00;
			rsp_last    <= 1'b0;
			rsp_idx_reg <= 6'h00;
		end else if (end_rx && is_cmd_reg) begin
			rsp_valid   <= 1'b1;
			rsp_byte    <= `CSD_CMD_CODE; // [RQ9]
			rsp_last    <= 1'b0;
			rsp_idx_reg <= 6'h00;
		end else if (rsp_valid && rsp_ready) begin
			rsp_idx_reg <= rsp_idx_reg + 6'h01;
			rsp_byte    <= (rsp_idx_reg == `CSD_IDX_CMD) ?
				`CSD_STATUS_OK : 8'h00; // [RQ9]
			// byte 63 carries last, so raise it as byte 62 is taken [RQ9]
			rsp_last    <= (rsp_idx_reg == `CSD_LAST_IDX - 6'h01);
			if (rsp_last) begin
				rsp_valid <= 1'b0;
				rsp_last  <= 1'b0;
			end
		end
	end

	// ****************************************
	// checks
	// ****************************************
	sequence s_cmd_end;
		end_rx && is_cmd_reg;
	endsequence

	sequence s_reply_end;
		rsp_valid && rsp_ready && rsp_last;
	endsequence

	chk_apply_timing: assert property ( // [RQ10]
		@(posedge mclk) disable iff (!nrst)
		s_cmd_end |=> settings_update && rsp_valid
	) else $error("settings not applied after command");
	chk_echo_code: assert property ( // [RQ9]
		@(posedge mclk) disable iff (!nrst)
		s_cmd_end |=> rsp_byte == `CSD_CMD_CODE
	) else $error("reply byte 0 not echo");
	chk_status_ok: assert property ( // [RQ9]
		@(posedge mclk) disable iff (!nrst)
		s_cmd_end ##1 rsp_ready |=> rsp_byte == `CSD_STATUS_OK
	) else $error("reply byte 1 not ok");
	chk_hold_bit: assert property ( // [RQ8]
		@(posedge mclk) disable iff (!nrst)
		s_cmd_end |=> spi_hold_bus == $past(other_stage[`CSD_BIT_HOLD])
	) else $error("spi hold bit wrong");
	chk_wake_bit: assert property ( // [RQ6]
		@(posedge mclk) disable iff (!nrst)
		s_cmd_end |=> wake_enable == $past(other_stage[`CSD_BIT_WAKE])
	) else $error("wake bit wrong");
	chk_irq_mode: assert property ( // [RQ7]
		@(posedge mclk) disable iff (!nrst)
		s_cmd_end |=> irq_count_mode ==
			$past(other_stage[`CSD_BIT_IRQ_HI:`CSD_BIT_IRQ_LO])
	) else $error("irq mode wrong");
	chk_func_apply: assert property ( // [RQ3]
		@(posedge mclk) disable iff (!nrst)
		s_cmd_end |=> pin_func == $past(func_stage)
	) else $error("pin functions not applied");
	chk_level_dir: assert property ( // [RQ4] [RQ5]
		@(posedge mclk) disable iff (!nrst)
		s_cmd_end |=> gpio_out_default == $past(out_stage) &&
			gpio_dir_default == $past(dir_stage)
	) else $error("levels or directions not applied");
	chk_foreign_cmd: assert property ( // [RQ1]
		@(posedge mclk) disable iff (!nrst)
		end_rx && !is_cmd_reg |=> !rsp_valid && $stable(pin_func)
	) else $error("foreign command acted on");
	chk_stable_rx: assert property ( // [RQ2]
		@(posedge mclk) disable iff (!nrst)
		!(end_rx && is_cmd_reg) |=> $stable(gpio_dir_default)
	) else $error("directions changed outside command end");
	chk_update_pulse: assert property ( // [RQ10]
		@(posedge mclk) disable iff (!nrst)
		settings_update |=> !settings_update
	) else $error("update pulse longer than one cycle");
	chk_refuse_busy: assert property ( // [RQ9]
		@(posedge mclk) disable iff (!nrst)
		state_reg == CSD_ST_RESP |-> !cmd_ready
	) else $error("command byte accepted while reply pending");
	chk_last_index: assert property ( // [RQ9]
		@(posedge mclk) disable iff (!nrst)
		rsp_valid |-> rsp_last == (rsp_idx_reg == `CSD_LAST_IDX)
	) else $error("last flag not on reply byte 63");
	chk_reply_end: assert property ( // [RQ9]
		@(posedge mclk) disable iff (!nrst)
		s_reply_end |=> !rsp_valid && cmd_ready
	) else $error("reply did not close after last byte");
endmodule

// ===== bench/csd_host.sv
// host model that sends command reports and takes the replies
module csd_host (
	// clock
	input  wire logic       mclk,
	// command report stream
	input  wire logic       cmd_ready,
	output logic            cmd_valid,
	output logic [7:0]      cmd_byte,
	// reply stream
	input  wire logic       rsp_valid,
	output logic            rsp_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] stall_reg = 2'h0;
	initial begin
		cmd_valid = 1'b0;
		cmd_byte  = 8'h00;
		rsp_ready = 1'b0;
	end
	// a busy host drops rsp_ready one cycle in four
	always @(posedge mclk) begin
		stall_reg <= stall_reg + 2'h1;
		rsp_ready <= (stall_reg != 2'h3);
	end
	task automatic send(input logic [7:0] r [64]);
		for (int i = 0; i < 64; i++) begin
			cmd_valid <= 1'b1;
			cmd_byte  <= r[i];
			do @(posedge mclk); while (cmd_ready !== 1'b1);
		end
		// released data shows no stale byte
		cmd_valid <= 1'b0;
		cmd_byte  <= ~r[63];
		@(posedge mclk);
	endtask
endmodule

// ===== bench/tb_top.sv
// self-checking testbench of the chip settings command decoder
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        mclk = 1'b0, nrst = 1'b0;
	logic        cmd_valid, cmd_ready, rsp_valid, rsp_last, rsp_ready;
	logic        wake_enable, spi_hold_bus, settings_update;
	logic [7:0]  cmd_byte, rsp_byte, gpio_out_default, gpio_dir_default;
	logic [17:0] pin_func;
	logic [2:0]  irq_count_mode;
	logic [63:0] exp_q [$];
	logic [63:0] last;
	int          mismatches = 0, samples_checked = 0;
	int          ridx = 0, nrsp = 0, cycles = 0;
	csd_decoder i_csd_decoder (.mclk, .nrst, .cmd_valid, .cmd_byte,
		.cmd_ready, .rsp_valid, .rsp_byte, .rsp_last, .rsp_ready,
		.pin_func, .gpio_out_default, .gpio_dir_default, .wake_enable,
		.irq_count_mode, .spi_hold_bus, .settings_update);
	csd_host i_csd_host (.mclk, .cmd_ready, .cmd_valid, .cmd_byte,
		.rsp_valid, .rsp_ready);
	always #10 mclk = ~mclk;
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [63:0] pack(input logic [7:0] r [64]);
		logic [17:0] f;
		for (int n = 0; n < 9; n++) f[2*n +: 2] = r[4+n][1:0];
		return {25'h0, f, r[13], r[15], r[17][4], r[17][3:1], r[17][0]};
	endfunction
	function automatic logic [63:0] seen();
		return {25'h0, pin_func, gpio_out_default, gpio_dir_default,
			wake_enable, irq_count_mode, spi_hold_bus};
	endfunction
	task automatic check(input string nm, input logic [63:0] v, e);
		samples_checked++;
		if (v !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, e, v);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// monitor: every update takes the oldest note off the queue
	always @(posedge mclk) begin
		cycles++;
		if (nrst && settings_update === 1'b1) begin
			if (exp_q.size() == 0) check("stray_update", 1, 0);
			else check("settings", seen(), exp_q.pop_front());
		end
		if (nrst && rsp_valid === 1'b1 && rsp_ready === 1'b1) begin
			check("rsp_byte", rsp_byte, (ridx == 0) ? 8'h21 : 8'h00);
			check("rsp_last", rsp_last, ridx == 63);
			nrsp += (ridx == 63);
			ridx = (ridx + 1) % 64;
		end
		// limit ran out: counted as a mismatch, nothing follows it here
		if (cycles == 20000) begin
			mismatches++;
			give_verdict();
		end
	end
	initial begin
		logic [7:0]  r [64];
		logic [15:0] s;
		s = 16'h19FE;
		repeat (20) @(posedge mclk);
		nrst <= 1'b1;
		@(posedge mclk);
		@(negedge mclk);
		last = {25'h0, 18'h0, 8'h00, 8'hFF, 5'h00};
		check("reset_values", seen(), last);
		check("reset_ready", {cmd_ready, rsp_valid}, 2'b10);
		@(posedge mclk);
		// six commands walk all modes, the seventh has a foreign code,
		// the eighth follows a reset in mid-run
		for (int k = 0; k < 8; k++) begin
			if (k == 7) begin
				repeat (2) @(posedge mclk);
				check("unchanged", seen(), last);
				nrst <= 1'b0;
				repeat (3) @(posedge mclk);
				nrst <= 1'b1;
				@(posedge mclk);
				@(negedge mclk);
				last = {25'h0, 18'h0, 8'h00, 8'hFF, 5'h00};
				check("reset_again", seen(), last);
				check("ready_again", {cmd_ready, rsp_valid}, 2'b10);
				@(posedge mclk);
			end
			for (int i = 0; i < 64; i++) begin
				s = lfsr(s);
				r[i] = (i == 14 || i == 16) ? s[7:0] : 8'h00;
			end
			r[0] = (k == 6) ? 8'h5A : 8'h21;
			for (int n = 0; n < 8; n++) r[4+n] = 8'((k + n) % 3);
			r[12] = k[0] ? 8'h02 : 8'h00;
			r[13] = s[15:8];
			s = lfsr(s);
			r[15] = s[7:0];
			r[16][0] = 1'b1;
			r[17] = {s[15:12], 3'(k % 5), s[11]};
			if (k != 6) last = pack(r);
			if (k != 6) exp_q.push_back(last);
			i_csd_host.send(r);
		end
		// the last reply is still draining; wait until input opens again
		do @(posedge mclk); while (cmd_ready !== 1'b1);
		repeat (2) @(posedge mclk);
		check("final", seen(), last);
		check("replies", nrsp, 7);
		check("pending", exp_q.size(), 0);
		give_verdict();
	end
endmodule
